// *** tb/itc_host.sv ***
`timescale 1ns/1ns
`default_nettype none

module itc_host (
    input wire logic clk,
    output logic [9:0] io_addr,
    output logic io_rd,
    output logic io_wr,
    output logic [7:0] io_wdata,
    output logic timer_clk,
    output logic refresh_req,
    input wire logic [7:0] io_rdata,
    input wire logic [7:0] io_rdata_oe
);
    initial begin
        io_addr = 10'h3FF;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_wdata = 8'h00;
        timer_clk = 1'b0;
        refresh_req = 1'b0;
    end

    // Idle bus parks on an unmapped address with inverted data, so stale values never match
    task automatic wr(input logic [9:0] a, input logic [7:0] dat);
        @(negedge clk);
        io_addr = a;
        io_wdata = dat;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        io_addr = 10'h3FF;
        io_wdata = ~dat;
    endtask

    task automatic rd(input logic [9:0] a, output logic [7:0] dat, output logic [7:0] oe);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        io_addr = 10'h3FF;
        dat = io_rdata;
        oe = io_rdata_oe;
    endtask

    // one common tick
    // Ten system clocks per tick keeps well clear of the synchroniser latency
    task automatic tick();
        timer_clk = 1'b1;
        repeat (5) @(negedge clk);
        timer_clk = 1'b0;
        repeat (5) @(negedge clk);
    endtask

    task automatic refresh();
        refresh_req = 1'b1;
        repeat (4) @(negedge clk);
        refresh_req = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule // itc_host

`default_nettype wire

// *** tb/itc_timer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module itc_timer_tb;
    logic clk = 1'b0;
    logic reset_n;
    logic [9:0] io_addr;
    logic io_rd;
    logic io_wr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic [7:0] io_rdata_oe;
    logic timer_clk;
    logic refresh_req;
    logic timer0_out;
    logic timer1_out;
    logic channel2_output;
    logic sound_output;
    logic [7:0] d;
    logic [7:0] oe;
    logic [3:0] pat;
    int err_count;
    int checked;
    int lows;

    always #5 clk = ~clk;

    itc_timer itc_timer_inst (.clk(clk), .reset_n(reset_n), .io_addr(io_addr), .io_rd(io_rd),
        .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
        .timer_clk(timer_clk), .refresh_req(refresh_req), .timer0_out(timer0_out),
        .timer1_out(timer1_out), .channel2_output(channel2_output),
        .sound_output(sound_output));

    itc_host itc_host_inst (.clk(clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
        .io_wdata(io_wdata), .timer_clk(timer_clk), .refresh_req(refresh_req),
        .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic rdchk(input string what, input logic [9:0] a, input logic [7:0] exp);
        itc_host_inst.rd(a, d, oe);
        check(what, d, exp);
    endtask

    initial begin
        reset_n = 1'b0;
        err_count = 0;
        checked = 0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        repeat (5) @(negedge clk);
        rdchk("port_reset", itc_pkg::PORT_SYS, 8'h20);
        check("port_oe", oe, itc_pkg::SYS_DRIVEN);
        itc_host_inst.rd(10'h050, d, oe);
        check("unmapped_oe", oe, 8'h00);
        itc_host_inst.wr(itc_pkg::PORT_SYS, 8'hFF);
        rdchk("port_rw", itc_pkg::PORT_SYS, 8'h2F);
        check("sound_on", sound_output, 1'b1);
        itc_host_inst.wr(itc_pkg::PORT_SYS, 8'h0C);
        rdchk("port_spk_off", itc_pkg::PORT_SYS, 8'h2C);
        check("sound_off", sound_output, 1'b0);
        itc_host_inst.refresh();
        itc_host_inst.wr(itc_pkg::PORT_SYS, 8'hF0);
        rdchk("port_refresh", itc_pkg::PORT_SYS, 8'h30);
        itc_host_inst.wr(itc_pkg::PORT_CTRL, 8'h38);
        itc_host_inst.wr(itc_pkg::PORT_CH0, 8'h02);
        itc_host_inst.wr(itc_pkg::PORT_CH0, 8'h00);
        itc_host_inst.wr(itc_pkg::PORT_CTRL, 8'hE2);
        rdchk("status_pend", itc_pkg::PORT_CH0, 8'hF8);
        pat = 4'b1101;
        for (int i = 0; i < 4; i++) begin
            itc_host_inst.tick();
            check("out0_strobe", timer0_out, pat[3 - i]);
        end
        itc_host_inst.wr(itc_pkg::PORT_CTRL, 8'h00);
        rdchk("wrap_lo", itc_pkg::PORT_CH0, 8'hFF);
        rdchk("wrap_hi", itc_pkg::PORT_CH0, 8'hFF);
        itc_host_inst.wr(itc_pkg::PORT_CTRL, 8'hE2);
        rdchk("status_run", itc_pkg::PORT_CH0, 8'hB8);
        itc_host_inst.wr(itc_pkg::PORT_CH0, 8'h05);
        itc_host_inst.wr(itc_pkg::PORT_CH0, 8'h00);
        itc_host_inst.tick();
        itc_host_inst.wr(itc_pkg::PORT_CTRL, 8'hD2);
        rdchk("reload_lo", itc_pkg::PORT_CH0, 8'h05);
        rdchk("reload_hi", itc_pkg::PORT_CH0, 8'h00);
        itc_host_inst.tick();
        rdchk("live_lo", itc_pkg::PORT_CH0, 8'h04);
        rdchk("live_hi", itc_pkg::PORT_CH0, 8'h00);
        // Channel 1 in mode 4 alongside channel 0, both snapshotted by one readback
        itc_host_inst.wr(itc_pkg::PORT_CTRL, 8'h78);
        itc_host_inst.wr(itc_pkg::PORT_CH0 + 10'h001, 8'h03);
        itc_host_inst.wr(itc_pkg::PORT_CH0 + 10'h001, 8'h00);
        itc_host_inst.tick();
        check("out1_start", timer1_out, 1'b1);
        itc_host_inst.wr(itc_pkg::PORT_CTRL, 8'hD6);
        itc_host_inst.tick();
        rdchk("snap0_lo", itc_pkg::PORT_CH0, 8'h03);
        rdchk("snap0_hi", itc_pkg::PORT_CH0, 8'h00);
        rdchk("snap1_lo", itc_pkg::PORT_CH0 + 10'h001, 8'h03);
        rdchk("snap1_hi", itc_pkg::PORT_CH0 + 10'h001, 8'h00);
        repeat (2) itc_host_inst.tick();
        check("out1_strobe", timer1_out, 1'b0);
        check("out0_common", timer0_out, 1'b0);
        // Gate high before loading so no gate edge competes with the load
        itc_host_inst.wr(itc_pkg::PORT_SYS, 8'h03);
        itc_host_inst.wr(itc_pkg::PORT_CTRL, 8'hBA);
        itc_host_inst.wr(itc_pkg::PORT_CH2, 8'h02);
        itc_host_inst.wr(itc_pkg::PORT_CH2, 8'h00);
        lows = 0;
        for (int i = 0; i < 5; i++) begin
            itc_host_inst.tick();
            lows += (channel2_output === 1'b0) ? 1 : 0;
            check("m5_out", channel2_output, (i != 2));
            check("sound_follow", sound_output, (i != 2));
        end
        check("m5_low_ticks", 16'(lows), 16'h0001);
        itc_host_inst.wr(itc_pkg::PORT_CTRL, 8'hB6);
        itc_host_inst.wr(itc_pkg::PORT_CH2, 8'h03);
        itc_host_inst.wr(itc_pkg::PORT_CH2, 8'h00);
        itc_host_inst.tick();
        lows = 0;
        // Two whole periods, so the count does not depend on where the phase starts
        for (int i = 0; i < 6; i++) begin
            itc_host_inst.tick();
            lows += (channel2_output === 1'b0) ? 1 : 0;
        end
        check("m3_low_ticks", 16'(lows), 16'h0002);
        for (int i = 0; i < 4 && channel2_output !== 1'b0; i++) begin
            itc_host_inst.tick();
        end
        check("m3_low_seen", channel2_output, 1'b0);
        itc_host_inst.wr(itc_pkg::PORT_SYS, 8'h02);
        repeat (4) @(negedge clk);
        check("m3_gate_low", channel2_output, 1'b1);
        wrap_up();
    end
endmodule // itc_timer_tb

`default_nettype wire

// *** verilog/itc_pkg.sv ***
package itc_pkg;

    // Host I/O ports
    localparam logic [9:0] PORT_CH0 = 10'h040;
    localparam logic [9:0] PORT_CH2 = 10'h042;
    localparam logic [9:0] PORT_CTRL = 10'h043;
    localparam logic [9:0] PORT_SYS = 10'h061;

    // Control word fields
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LO = 2'h1;
    localparam logic [1:0] ACC_HI = 2'h2;
    localparam logic [1:0] ACC_LOHI = 2'h3;
    localparam logic [2:0] MODE4 = 3'h4;
    localparam logic [2:0] MODE5 = 3'h5;
    localparam logic [1:0] MODE3_LOW = 2'h3;

    // System control port bit positions
    localparam int SYS_CHANNEL2_ENABLE_INPUT = 0;
    localparam int SYS_SPK = 1;
    localparam int SYS_REFRESH = 4;
    localparam int SYS_CHANNEL2_OUTPUT = 5;
    localparam logic [7:0] SYS_DRIVEN = 8'h3F;

    // Full-range lengths for a zero count
    localparam logic [16:0] LEN_BIN_MAX = 17'h10000;
    localparam logic [16:0] LEN_BCD_MAX = 17'h02710;

    typedef struct packed {
        logic [2:0][15:0] cnt;
        logic [2:0][15:0] rld;
        logic [2:0][15:0] lat;
        logic [2:0][16:0] ph;
        logic [2:0][7:0] wlo;
        logic [2:0][7:0] sts;
        logic [2:0][2:0] mode;
        logic [2:0][1:0] acc;
        logic [2:0] bcd;
        logic [2:0] out;
        logic [2:0] armed;
        logic [2:0] pend;
        logic [2:0] latv;
        logic [2:0] stv;
        logic [2:0] rdhi;
        logic [2:0] wrhi;
        logic [2:0] trig;
        logic [2:0] tck;
        logic [2:0] rfr;
        logic [3:0] sys;
        logic rtog;
        logic gd;
        logic snd;
        logic [7:0] rdata;
        logic [7:0] roe;
    } itc_state_s;

    localparam itc_state_s ST_RST = '{acc: {3{ACC_LOHI}}, out: 3'h7, default: '0};

endpackage

// *** verilog/itc_timer.sv ***
// Contract
// RULE1 - Mode 3 starts on load, reloads at zero, counts with gate high, gate rise reloads
// RULE2 - Mode 3 output high at start, low after half count, forced high by gate low
// RULE3 - Mode 3 new count loads at next zero or gate rising edge
// RULE4 - Mode 4 starts on load, counts with gate high, wraps to FFFF or 9999
// RULE5 - Mode 4 output pulses low one tick at zero; new count loads next tick
// RULE6 - Mode 5 starts on load, gate rise reloads, wraps to FFFF or 9999
// RULE7 - Mode 5 output low one tick at zero; new count at zero or gate rise
// RULE8 - Plain counter read returns the live count, possibly inconsistent between bytes
// RULE9 - Snapshot command freezes a copy of the count while counting continues
// RULE10 - Readback command snapshots every selected counter in one operation
// RULE11 - Readback with status bit low captures status, returned by next read
// RULE12 - Status bits 0-5 echo programmed fields, bit 7 shows output level
// RULE13 - Status bit 6 flags a written count not yet loaded
// RULE14 - Snapshot never captures a counter value that is still changing
// RULE15 - Control port read drives bits 0-5 only, bits 6-7 left undriven
// RULE16 - Control port bit 5 reads channel 2 output, writes ignored
// RULE17 - Control port bit 4 toggles on each refresh request, read only
// RULE18 - Control port bits 3 and 2 are plain storage with no effect
// RULE19 - Control port bit 0 gates channel 2, bit 1 enables speaker
// RULE20 - All counters run on the common timer clock; gates 0 and 1 high
// RULE21 - Host writes a control word first, then the count bytes it calls for
// RULE22 - Control word with top bits 11 is a readback command
// RULE23 - Sound output is channel 2 output AND speaker enable
// RULE24 - Odd mode 3 count keeps output high one tick longer than low
`timescale 1ns/1ns
`default_nettype none

module itc_timer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [9:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic [7:0] io_rdata_oe,
    input wire logic timer_clk,
    input wire logic refresh_req,
    output logic timer0_out,
    output logic timer1_out,
    output logic channel2_output,
    output logic sound_output
);

    logic [1:0] rst_sync_r;
    logic rst_n;
    itc_pkg::itc_state_s st_r;
    itc_pkg::itc_state_s st_nxt;
    logic tick;
    logic gate_rise;
    logic channel2_enable_input;

    // Decrement, wrapping from zero to FFFF or 9999
    function automatic logic [15:0] dec_cnt(input logic [15:0] v, input logic b);
        logic [15:0] r;
        logic brw;
        r = v - 16'h0001;
        brw = 1'b1;
        if (b) begin
            r = v;
            for (int k = 0; k < 4; k++) begin
                if (brw) begin
                    if (r[4*k +: 4] == 4'h0) begin
                        r[4*k +: 4] = 4'h9;
                    end else begin
                        r[4*k +: 4] = r[4*k +: 4] - 4'h1;
                        brw = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    // Period in ticks of a reload value; zero means the full range
    function automatic logic [16:0] len_of(input logic [15:0] v, input logic b);
        logic [16:0] n;
        n = {1'b0, v};
        if (b) begin
            n = 17'(v[15:12]) * 17'h003E8 + 17'(v[11:8]) * 17'h00064
                + 17'(v[7:4]) * 17'h0000A + 17'(v[3:0]);
        end
        if (n == 17'h00000) begin
            n = b ? itc_pkg::LEN_BCD_MAX : itc_pkg::LEN_BIN_MAX;
        end
        return n;
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // RULE20 common tick
    assign tick = st_r.tck[1] & ~st_r.tck[2];
    // RULE19 gate from port
    assign channel2_enable_input = st_r.sys[itc_pkg::SYS_CHANNEL2_ENABLE_INPUT];
    assign gate_rise = channel2_enable_input & ~st_r.gd;

    always_comb begin
        logic g;
        logic rt;
        logic m3;
        logic tm;
        logic [16:0] ln;
        logic [16:0] pn;
        logic [15:0] dv;
        logic [15:0] src;
        logic [1:0] ch;
        logic chsel;
        g = 1'b1;
        rt = 1'b0;
        m3 = 1'b0;
        tm = 1'b0;
        ln = 17'h00000;
        pn = 17'h00000;
        dv = 16'h0000;
        src = 16'h0000;
        ch = io_addr[1:0];
        chsel = (io_addr >= itc_pkg::PORT_CH0) && (io_addr <= itc_pkg::PORT_CH2);
        st_nxt = st_r;
        st_nxt.tck = {st_r.tck[1:0], timer_clk};
        st_nxt.rfr = {st_r.rfr[1:0], refresh_req};
        st_nxt.gd = channel2_enable_input;
        // Enable lasts one cycle so the shared data lines are released at once
        st_nxt.roe = 8'h00;
        // RULE17 refresh toggle
        if (st_r.rfr[1] && !st_r.rfr[2]) begin
            st_nxt.rtog = ~st_r.rtog;
        end
        for (int i = 0; i < 3; i++) begin
            // RULE20 gates 0 and 1 held high
            g = (i == 2) ? channel2_enable_input : 1'b1;
            m3 = st_r.mode[i][1:0] == itc_pkg::MODE3_LOW;
            rt = m3 || (st_r.mode[i] == itc_pkg::MODE5);
            ln = len_of(st_r.rld[i], st_r.bcd[i]);
            tm = m3 ? (st_r.ph[i] == ln - 17'h00001) : (st_r.cnt[i] == 16'h0000);
            dv = dec_cnt(st_r.cnt[i], st_r.bcd[i]);
            if (tick) begin
                st_nxt.trig[i] = 1'b0;
                // RULE3 pending load at zero or gate rise
                // RULE5 mode 4 pending load next tick
                // RULE7 mode 5 pending load
                if (st_r.pend[i] && (!st_r.armed[i] || !rt || st_r.trig[i] || (tm && g))) begin
                    st_nxt.cnt[i] = st_r.rld[i];
                    st_nxt.ph[i] = 17'h00000;
                    st_nxt.pend[i] = 1'b0;
                    st_nxt.armed[i] = 1'b1;
                    st_nxt.out[i] = 1'b1;
                // RULE1 gate rise reloads
                // RULE6 mode 5 retrigger
                end else if (st_r.armed[i] && rt && st_r.trig[i]) begin
                    st_nxt.cnt[i] = st_r.rld[i];
                    st_nxt.ph[i] = 17'h00000;
                    st_nxt.out[i] = 1'b1;
                end else if (st_r.armed[i] && g) begin
                    // RULE4 decrement and wrap
                    st_nxt.cnt[i] = dv;
                    if (m3) begin
                        // RULE1 reload at end
                        pn = tm ? 17'h00000 : st_r.ph[i] + 17'h00001;
                        st_nxt.ph[i] = pn;
                        if (tm) begin
                            st_nxt.cnt[i] = st_r.rld[i];
                        end
                        // RULE24 odd count high longer
                        // RULE2 low after half
                        st_nxt.out[i] = pn < ((ln + 17'h00001) >> 1);
                    end else begin
                        // RULE5 one tick low at zero
                        st_nxt.out[i] = dv != 16'h0000;
                    end
                end else if (!m3) begin
                    st_nxt.out[i] = 1'b1;
                end
            end
            // Edge seen between ticks is held until the next tick
            if (i == 2 && rt && gate_rise) begin
                st_nxt.trig[i] = 1'b1;
            end
            // RULE2 gate low forces high
            if (m3 && !g) begin
                st_nxt.out[i] = 1'b1;
            end
        end
        if (io_wr && io_addr == itc_pkg::PORT_CTRL) begin
            // RULE22 readback decode
            if (io_wdata[7:6] == itc_pkg::SEL_READBACK) begin
                for (int i = 0; i < 3; i++) begin
                    if (io_wdata[i + 1]) begin
                        // RULE10 snapshot all selected
                        // RULE14 count is stable in its flops
                        if (!io_wdata[5] && !st_r.latv[i]) begin
                            st_nxt.lat[i] = st_r.cnt[i];
                            st_nxt.latv[i] = 1'b1;
                        end
                        // RULE11 status capture
                        // RULE12 status fields
                        // RULE13 pending flag
                        if (!io_wdata[4] && !st_r.stv[i]) begin
                            st_nxt.sts[i] = {st_r.out[i], st_r.pend[i], st_r.acc[i],
                                st_r.mode[i], st_r.bcd[i]};
                            st_nxt.stv[i] = 1'b1;
                        end
                    end
                end
            // RULE9 count snapshot
            end else if (io_wdata[5:4] == itc_pkg::ACC_LATCH) begin
                // A second snapshot while one is unread is dropped; the first wins
                if (!st_r.latv[io_wdata[7:6]]) begin
                    st_nxt.lat[io_wdata[7:6]] = st_r.cnt[io_wdata[7:6]];
                    st_nxt.latv[io_wdata[7:6]] = 1'b1;
                end
            end else begin
                st_nxt.acc[io_wdata[7:6]] = io_wdata[5:4];
                st_nxt.mode[io_wdata[7:6]] = io_wdata[3:1];
                st_nxt.bcd[io_wdata[7:6]] = io_wdata[0];
                st_nxt.armed[io_wdata[7:6]] = 1'b0;
                st_nxt.pend[io_wdata[7:6]] = 1'b0;
                st_nxt.out[io_wdata[7:6]] = 1'b1;
                st_nxt.wrhi[io_wdata[7:6]] = 1'b0;
                st_nxt.rdhi[io_wdata[7:6]] = 1'b0;
                st_nxt.latv[io_wdata[7:6]] = 1'b0;
                st_nxt.stv[io_wdata[7:6]] = 1'b0;
                st_nxt.trig[io_wdata[7:6]] = 1'b0;
            end
        end
        if (io_wr && chsel) begin
            case (st_r.acc[ch])
                itc_pkg::ACC_LO: begin
                    st_nxt.rld[ch] = {8'h00, io_wdata};
                    st_nxt.pend[ch] = 1'b1;
                end
                itc_pkg::ACC_HI: begin
                    st_nxt.rld[ch] = {io_wdata, 8'h00};
                    st_nxt.pend[ch] = 1'b1;
                end
                itc_pkg::ACC_LOHI: begin
                    st_nxt.wrhi[ch] = ~st_r.wrhi[ch];
                    if (st_r.wrhi[ch]) begin
                        st_nxt.rld[ch] = {io_wdata, st_r.wlo[ch]};
                        st_nxt.pend[ch] = 1'b1;
                    end else begin
                        st_nxt.wlo[ch] = io_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        // RULE18 bits 3 and 2 stored only
        // RULE16 bit 5 write ignored
        if (io_wr && io_addr == itc_pkg::PORT_SYS) begin
            st_nxt.sys = io_wdata[3:0];
        end
        if (io_rd && io_addr == itc_pkg::PORT_SYS) begin
            // RULE15 bits 6 and 7 undriven
            st_nxt.roe = itc_pkg::SYS_DRIVEN;
            st_nxt.rdata = 8'h00;
            st_nxt.rdata[3:0] = st_r.sys;
            st_nxt.rdata[itc_pkg::SYS_REFRESH] = st_r.rtog;
            // RULE16 live channel 2 output
            st_nxt.rdata[itc_pkg::SYS_CHANNEL2_OUTPUT] = st_r.out[2];
        end else if (io_rd && chsel) begin
            st_nxt.roe = 8'hFF;
            // RULE11 status read first
            if (st_r.stv[ch]) begin
                st_nxt.rdata = st_r.sts[ch];
                st_nxt.stv[ch] = 1'b0;
            end else begin
                // RULE8 live count unless latched
                src = st_r.latv[ch] ? st_r.lat[ch] : st_r.cnt[ch];
                if (st_r.acc[ch] == itc_pkg::ACC_HI
                    || (st_r.acc[ch] == itc_pkg::ACC_LOHI && st_r.rdhi[ch])) begin
                    st_nxt.rdata = src[15:8];
                end else begin
                    st_nxt.rdata = src[7:0];
                end
                if (st_r.acc[ch] == itc_pkg::ACC_LOHI) begin
                    st_nxt.rdhi[ch] = ~st_r.rdhi[ch];
                end
                if (st_r.acc[ch] != itc_pkg::ACC_LOHI || st_r.rdhi[ch]) begin
                    st_nxt.latv[ch] = 1'b0;
                end
            end
        end
        // RULE23 speaker gating
        st_nxt.snd = st_nxt.out[2] & st_nxt.sys[itc_pkg::SYS_SPK];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= itc_pkg::ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign io_rdata = st_r.rdata;
    assign io_rdata_oe = st_r.roe;
    assign timer0_out = st_r.out[0];
    assign timer1_out = st_r.out[1];
    assign channel2_output = st_r.out[2];
    assign sound_output = st_r.snd;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_sound_gating: assert property (sound_output == (channel2_output & st_r.sys[1])) // RULE23
        else $error("sound output does not follow channel 2 and enable");
    a_gate_low_high: assert property ((st_r.mode[2][1:0] == 2'h3 && !st_r.sys[0]) // RULE2
        |=> channel2_output)
        else $error("mode 3 output not high with gate low");
    a_strobe_width: assert property ((st_r.mode[0] == 3'h4 && !timer0_out && tick) // RULE5
        |=> timer0_out)
        else $error("mode 4 strobe longer than one tick");
    a_strobe_at_zero: assert property ((st_r.mode[0] == 3'h4 && $fell(timer0_out)) // RULE5
        |-> st_r.cnt[0] == 16'h0000)
        else $error("mode 4 strobe without zero count");
    a_snapshot_hold: assert property ((st_r.latv[0] && $past(st_r.latv[0])) // RULE9
        |-> $stable(st_r.lat[0]))
        else $error("snapshot changed while held");
    a_pending_next: assert property ((st_r.mode[0] == 3'h4 && st_r.pend[0] // RULE5
        && st_r.armed[0] && tick && !io_wr) |=> !st_r.pend[0])
        else $error("mode 4 count not loaded on next tick");
    a_status_fields: assert property ($rose(st_r.stv[0]) |-> (st_r.sts[0][5:0] // RULE12
        == {st_r.acc[0], st_r.mode[0], st_r.bcd[0]} && st_r.sts[0][7] == $past(st_r.out[0])))
        else $error("status byte fields wrong");
    a_sys_read: assert property ((io_rd && io_addr == itc_pkg::PORT_SYS) // RULE15
        |=> (io_rdata_oe == itc_pkg::SYS_DRIVEN
        && io_rdata[5] == $past(st_r.out[2]) && io_rdata[4] == $past(st_r.rtog)))
        else $error("control port read wrong");
    a_refresh_flip: assert property ((st_r.rfr[1] && !st_r.rfr[2]) // RULE17
        |=> st_r.rtog != $past(st_r.rtog))
        else $error("refresh flag did not toggle");

endmodule // itc_timer

`default_nettype wire
